// [verilog/sdcsf_pkg.sv]
// Constants shared by the stereo DAC clock and serial front end
package sdcsf_pkg;
    localparam int SAMPLE_W = 18;
    localparam int SHORT_W = 16;
    localparam int RATIO_LO = 256;
    localparam int RATIO_HI = 384;
    localparam int FILT_RATIO = 128;
    localparam int INTERP = 8;
    localparam int MOD_OSR = 64;
    localparam int LATENCY_WORDS = 33;
    localparam int CAL_WORDS = 1024;
    localparam int RESET_MIN_CYC = 2;
    localparam int STEP_LO = RATIO_LO / INTERP;
    localparam int STEP_HI = RATIO_HI / INTERP;
    localparam int FDIV_LO = RATIO_LO / FILT_RATIO;
    localparam int FDIV_HI = RATIO_HI / FILT_RATIO;
    localparam int BUF_DEPTH = LATENCY_WORDS - 1;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_LEFT = 4'h1;
    localparam logic [3:0] REG_RIGHT = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam int CTRL_RESTART_BIT = 0;
    localparam logic [1:0] FMT_RJ16 = 2'h0;
    localparam logic [1:0] FMT_RJ18 = 2'h1;
    localparam logic [1:0] FMT_LJ = 2'h2;
    localparam logic [1:0] FMT_I2S = 2'h3;
    typedef enum logic [2:0] {
        ST_KICK = 3'h1,
        ST_CAL = 3'h2,
        ST_RUN = 3'h4
    } sdcsf_state_e;
endpackage

// [verilog/sdcsf_chan.sv]
// One channel: 8x linear interpolation and first-order one-bit modulator
`timescale 1ns/1ns
`default_nettype none
module sdcsf_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic step_en,
    input wire logic word_en,
    input wire logic zero,
    input wire logic [17:0] sample,
    output logic bit_out
);
    logic signed [18:0] prev_q, prev_d;
    logic signed [18:0] delta_q, delta_d;
    logic signed [21:0] acc_q, acc_d;
    logic signed [24:0] integ_q, integ_d;
    logic bit_q, bit_d;
    logic signed [24:0] fb;

    always_comb begin
        prev_d = prev_q;
        delta_d = delta_q;
        acc_d = acc_q;
        fb = bit_q ? 25'sh0100000 : -25'sh0100000;
        if (step_en) begin
            acc_d = acc_q + 22'(delta_q);
        end
        if (word_en) begin
            prev_d = 19'(signed'(sample));
            delta_d = 19'(signed'(sample)) - prev_q;
        end
        if (zero) begin
            prev_d = '0;
            delta_d = '0;
            acc_d = '0;
        end
        // Modulator runs every master cycle, the fastest rate available
        integ_d = integ_q + 25'(acc_q) - fb;
        bit_d = ~integ_d[24];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_q <= '0;
            delta_q <= '0;
            acc_q <= '0;
            integ_q <= '0;
            bit_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            delta_q <= delta_d;
            acc_q <= acc_d;
            integ_q <= integ_d;
            bit_q <= bit_d;
        end
    end

    assign bit_out = bit_q;
endmodule
`default_nettype wire

// [verilog/sdcsf_top.sv]
// Stereo DAC front end: clocks, serial input, calibration, interpolation
// What this block does
// - Ratio select low means master is 256x word rate, high means 384x.
// - Word rate equals word clock rate; each period carries left and right.
// - Filter clock output runs at exactly 128x the word rate.
// - Formats 0,1,3 use rising bit clock edge; format 2 uses falling.
// - Samples pass 8x interpolation then a one-bit modulator.
// - Sample to output latency is 33 word periods.
// - Sample words may be 16 or 18 bits.
// - Two static format selects choose four formats, default low.
// - Master clock drives interpolation filter and modulator.
// - Filter band edges scale with the word rate.
// - Upper select is the high bit of the two-bit format number.
// - Samples arrive MSB first in two's complement.
// - Leaving reset runs 1024 word periods of calibration, output zero.
// - Calibration flag high from reset until post-reset calibration ends.
`timescale 1ns/1ns
`default_nettype none
module sdcsf_top #(
    parameter int CAL_WORDS = sdcsf_pkg::CAL_WORDS
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CLOCK_RATIO_SELECT,
    input wire logic FORMAT_SELECT_LO,
    input wire logic FORMAT_SELECT_HI,
    input wire logic SERIAL_BIT_CLOCK,
    input wire logic WORD_CHANNEL_CLOCK,
    input wire logic SERIAL_SAMPLE_IN,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic FILTER_CLOCK_OUT,
    output logic CALIBRATION_ACTIVE_OUT,
    output logic MOD_OUT_LEFT,
    output logic MOD_OUT_RIGHT
);
    localparam int SW = sdcsf_pkg::SAMPLE_W;
    localparam int BD = sdcsf_pkg::BUF_DEPTH;

    // Pin synchronisers; stage one feeds stage two only
    logic [5:0] pin_raw;
    logic [5:0] s1_q, s2_q;
    assign pin_raw = {CLOCK_RATIO_SELECT, FORMAT_SELECT_HI, FORMAT_SELECT_LO,
                      SERIAL_BIT_CLOCK, WORD_CHANNEL_CLOCK, SERIAL_SAMPLE_IN};
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end

    logic ratio_hi, bck, word_channel_clock, sdata;
    logic [1:0] fmt;
    assign ratio_hi = s2_q[5];
    assign fmt = s2_q[4:3];
    assign bck = s2_q[2];
    assign word_channel_clock = s2_q[1];
    assign sdata = s2_q[0];

    // Serial receiver state
    logic bck_prev_q, bck_prev_d;
    logic lr_prev_q, lr_prev_d;
    logic lr_last_q, lr_last_d;
    logic [SW-1:0] sh_q, sh_d;
    logic [4:0] bcnt_q, bcnt_d;
    logic [SW-1:0] left_q, left_d, right_q, right_d;
    logic act, lr_chg, lr_rise, cap_en, cap_left;
    logic [SW-1:0] cap_val;

    always_comb begin
        bck_prev_d = bck;
        lr_prev_d = word_channel_clock;
        lr_rise = word_channel_clock & ~lr_prev_q;
        act = (fmt == sdcsf_pkg::FMT_LJ) ? (~bck & bck_prev_q) : (bck & ~bck_prev_q);
        lr_chg = act & (word_channel_clock != lr_last_q);
        lr_last_d = act ? word_channel_clock : lr_last_q;
        sh_d = act ? {sh_q[SW-2:0], sdata} : sh_q;
        bcnt_d = bcnt_q;
        if (lr_chg) begin
            bcnt_d = '0;
        end else if (act && bcnt_q != 5'h1f) begin
            bcnt_d = bcnt_q + 5'h01;
        end
        cap_en = 1'b0;
        cap_left = word_channel_clock;
        cap_val = sh_d;
        case (fmt)
            sdcsf_pkg::FMT_RJ16: begin
                // Right-justified: the word just ended sits in the shifter
                cap_en = lr_chg;
                cap_left = lr_last_q;
                cap_val = {sh_q[sdcsf_pkg::SHORT_W-1:0], 2'h0};
            end
            sdcsf_pkg::FMT_RJ18: begin
                cap_en = lr_chg;
                cap_left = lr_last_q;
                cap_val = sh_q;
            end
            sdcsf_pkg::FMT_LJ: begin
                cap_en = act && !lr_chg && bcnt_q == 5'(SW - 2);
            end
            sdcsf_pkg::FMT_I2S: begin
                // One bit delay; word clock low marks the left word
                cap_en = act && !lr_chg && bcnt_q == 5'(SW - 1);
                cap_left = ~word_channel_clock;
            end
            default: begin
                cap_en = 1'b0;
            end
        endcase
        left_d = (cap_en && cap_left) ? cap_val : left_q;
        right_d = (cap_en && !cap_left) ? cap_val : right_q;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            bck_prev_q <= 1'b0;
            lr_prev_q <= 1'b0;
            lr_last_q <= 1'b0;
            sh_q <= '0;
            bcnt_q <= '0;
            left_q <= '0;
            right_q <= '0;
        end else begin
            bck_prev_q <= bck_prev_d;
            lr_prev_q <= lr_prev_d;
            lr_last_q <= lr_last_d;
            sh_q <= sh_d;
            bcnt_q <= bcnt_d;
            left_q <= left_d;
            right_q <= right_d;
        end
    end

    // Calibration sequencer
    sdcsf_pkg::sdcsf_state_e st_q, st_d;
    logic [10:0] cal_cnt_q, cal_cnt_d;
    logic restart, resync;

    assign restart = REG_WR && REG_ADDR == sdcsf_pkg::REG_CTRL
        && REG_WDATA[sdcsf_pkg::CTRL_RESTART_BIT];

    always_comb begin
        st_d = st_q;
        cal_cnt_d = cal_cnt_q;
        resync = 1'b0;
        case (st_q)
            sdcsf_pkg::ST_KICK: begin
                // Filter clock stays idle until the word clock rises
                if (lr_rise) begin
                    st_d = sdcsf_pkg::ST_CAL;
                    cal_cnt_d = '0;
                    resync = 1'b1;
                end
            end
            sdcsf_pkg::ST_CAL: begin
                if (lr_rise) begin
                    cal_cnt_d = cal_cnt_q + 11'h001;
                    if (cal_cnt_q == 11'(CAL_WORDS - 1)) begin
                        st_d = sdcsf_pkg::ST_RUN;
                    end
                end
            end
            sdcsf_pkg::ST_RUN: begin
                st_d = sdcsf_pkg::ST_RUN;
            end
            default: begin
                st_d = sdcsf_pkg::ST_KICK;
            end
        endcase
        if (restart && st_q != sdcsf_pkg::ST_KICK) begin
            st_d = sdcsf_pkg::ST_CAL;
            cal_cnt_d = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st_q <= sdcsf_pkg::ST_KICK;
            cal_cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cal_cnt_q <= cal_cnt_d;
        end
    end

    logic running, active;
    assign running = (st_q == sdcsf_pkg::ST_RUN);
    assign active = (st_q != sdcsf_pkg::ST_KICK);

    // Clock dividers: filter clock, interpolation step and word tick
    logic [1:0] fdiv_q, fdiv_d;
    logic fclk_q, fclk_d;
    logic [5:0] sdiv_q, sdiv_d;
    logic [2:0] step_q, step_d;
    logic step_en, word_en;
    logic [1:0] fdiv_max;
    logic [5:0] sdiv_max;

    always_comb begin
        fdiv_max = ratio_hi ? 2'(sdcsf_pkg::FDIV_HI - 1) : 2'(sdcsf_pkg::FDIV_LO - 1);
        sdiv_max = ratio_hi ? 6'(sdcsf_pkg::STEP_HI - 1) : 6'(sdcsf_pkg::STEP_LO - 1);
        fdiv_d = (fdiv_q >= fdiv_max) ? 2'h0 : fdiv_q + 2'h1;
        step_en = active && sdiv_q == sdiv_max;
        sdiv_d = (sdiv_q >= sdiv_max) ? 6'h00 : sdiv_q + 6'h01;
        step_d = step_en ? step_q + 3'h1 : step_q;
        word_en = step_en && step_q == 3'(sdcsf_pkg::INTERP - 1);
        if (resync || !active) begin
            // Internal word timing restarts on the kick edge
            fdiv_d = '0;
            sdiv_d = '0;
            step_d = '0;
        end
        fclk_d = active && fdiv_d == 2'h0;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            fdiv_q <= '0;
            fclk_q <= 1'b0;
            sdiv_q <= '0;
            step_q <= '0;
        end else begin
            fdiv_q <= fdiv_d;
            fclk_q <= fclk_d;
            sdiv_q <= sdiv_d;
            step_q <= step_d;
        end
    end

    // Latency line: 32 words here plus one of interpolation lag
    logic [2*SW-1:0] dly_q [BD];
    logic [2*SW-1:0] dly_d [BD];
    logic [4:0] wp_q, wp_d;
    logic [2*SW-1:0] dly_out_q, dly_out_d;

    always_comb begin
        dly_d = dly_q;
        wp_d = wp_q;
        dly_out_d = dly_out_q;
        if (word_en) begin
            dly_out_d = dly_q[wp_q];
            dly_d[wp_q] = {left_q, right_q};
            wp_d = (wp_q == 5'(BD - 1)) ? 5'h00 : wp_q + 5'h01;
        end
        if (!running) begin
            dly_out_d = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            dly_q <= '{default: '0};
            wp_q <= '0;
            dly_out_q <= '0;
        end else begin
            dly_q <= dly_d;
            wp_q <= wp_d;
            dly_out_q <= dly_out_d;
        end
    end

    // Channels run from the master clock
    logic [1:0] mod_bits;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            sdcsf_chan u_chan (
                .clk(CLK),
                .rstn(RSTN),
                .step_en(step_en),
                .word_en(word_en),
                .zero(!running),
                .sample(dly_out_q[gi*SW +: SW]),
                .bit_out(mod_bits[gi])
            );
        end
    endgenerate

    // Register read port, data one cycle after the strobe
    logic [15:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                sdcsf_pkg::REG_STATUS: begin
                    rdata_d = {9'h000, st_q, fmt, ratio_hi, ~running};
                end
                sdcsf_pkg::REG_LEFT: begin
                    rdata_d = left_q[SW-1:2];
                end
                sdcsf_pkg::REG_RIGHT: begin
                    rdata_d = right_q[SW-1:2];
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    logic cal_q, cal_d;
    assign cal_d = !running;
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cal_q <= 1'b1;
        end else begin
            cal_q <= cal_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign FILTER_CLOCK_OUT = fclk_q;
    assign CALIBRATION_ACTIVE_OUT = cal_q;
    assign MOD_OUT_LEFT = mod_bits[1];
    assign MOD_OUT_RIGHT = mod_bits[0];
endmodule
`default_nettype wire

// [verif/sdcsf_chk.sv]
// Port assertions for the stereo DAC front end
`timescale 1ns/1ns
`default_nettype none
module sdcsf_chk #(
    parameter int CAL_WORDS = 4
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CLOCK_RATIO_SELECT,
    input wire logic FORMAT_SELECT_LO,
    input wire logic FORMAT_SELECT_HI,
    input wire logic WORD_CHANNEL_CLOCK,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic FILTER_CLOCK_OUT,
    input wire logic CALIBRATION_ACTIVE_OUT
);
    // Raw pin edges, counted ahead of the design's synchroniser
    logic wcc_q, wcc_d;
    logic [15:0] wcnt_q, wcnt_d;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    always_comb begin
        wcc_d = WORD_CHANNEL_CLOCK;
        wcnt_d = RSTN ? wcnt_q + 16'(WORD_CHANNEL_CLOCK && !wcc_q) : 16'h0;
    end
    always_ff @(posedge CLK) begin
        wcc_q <= wcc_d;
        wcnt_q <= wcnt_d;
    end
    rst_vals_a: assert property (
        $rose(RSTN) |-> CALIBRATION_ACTIVE_OUT && !FILTER_CLOCK_OUT)
        else $error("reset output values wrong");
    fclk_idle_a: assert property (
        $rose(RSTN) |-> !FILTER_CLOCK_OUT [*4])
        else $error("filter clock before kick");
    fclk_div2_a: assert property (
        FILTER_CLOCK_OUT && !CLOCK_RATIO_SELECT |=> !FILTER_CLOCK_OUT ##1 FILTER_CLOCK_OUT)
        else $error("filter clock not master over two");
    fclk_div3_a: assert property (
        FILTER_CLOCK_OUT && CLOCK_RATIO_SELECT |=> !FILTER_CLOCK_OUT [*2] ##1 FILTER_CLOCK_OUT)
        else $error("filter clock not master over three");
    cal_early_a: assert property (
        $fell(CALIBRATION_ACTIVE_OUT) |-> wcnt_q > CAL_WORDS)
        else $error("calibration ended early");
    cal_end_a: assert property (
        $rose(WORD_CHANNEL_CLOCK) && wcnt_q == CAL_WORDS && CALIBRATION_ACTIVE_OUT
        |-> ##[2:8] !CALIBRATION_ACTIVE_OUT)
        else $error("calibration flag stuck");
    stat_fmt_a: assert property (
        REG_RD && REG_ADDR == 4'h0 |=> REG_RDATA[3:2] == {FORMAT_SELECT_HI, FORMAT_SELECT_LO})
        else $error("format field wrong");
    stat_ratio_a: assert property (
        REG_RD && REG_ADDR == 4'h0 |=> REG_RDATA[1] == CLOCK_RATIO_SELECT)
        else $error("ratio field wrong");
endmodule
bind sdcsf_top sdcsf_chk #(.CAL_WORDS(CAL_WORDS)) u_chk (
    .CLK(CLK),
    .RSTN(RSTN),
    .CLOCK_RATIO_SELECT(CLOCK_RATIO_SELECT),
    .FORMAT_SELECT_LO(FORMAT_SELECT_LO),
    .FORMAT_SELECT_HI(FORMAT_SELECT_HI),
    .WORD_CHANNEL_CLOCK(WORD_CHANNEL_CLOCK),
    .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .FILTER_CLOCK_OUT(FILTER_CLOCK_OUT),
    .CALIBRATION_ACTIVE_OUT(CALIBRATION_ACTIVE_OUT)
);
`default_nettype wire

// [verif/sdcsf_src.sv]
// Serial sample source: bit clock, word clock and data from the master
`timescale 1ns/1ns
`default_nettype none
module sdcsf_src (
    input wire logic clk,
    input wire logic en,
    input wire logic ratio,
    input wire logic [1:0] fmt,
    input wire logic [17:0] l_smp,
    input wire logic [17:0] r_smp,
    output logic bck,
    output logic word_channel_clock,
    output logic sdat,
    output logic tick
);
    int off[4] = '{33, 31, 17, 18};
    int c, s, k;
    logic [17:0] cl, cr;
    initial {bck, word_channel_clock, sdat, tick} = 4'h0;
    always @(posedge clk) begin
        tick <= 1'b0;
        if (!en) begin
            c = 0;
            s = 63;
            bck <= fmt == 2'h2;
            word_channel_clock <= 1'b0;
            sdat <= ~sdat;
        end else begin
            if (c == 0) begin
                s = (s + 1) % 64;
                if (s == 0) begin
                    cl = l_smp;
                    cr = r_smp;
                    tick <= 1'b1;
                end
                word_channel_clock <= (s < 32) ^ (fmt == 2'h3);
                k = off[fmt] - s % 32;
                // Unused slots toggle so stale bits never look valid
                sdat <= (k < 0 || k > 17) ? ~sdat : (s < 32 ? cl[k] : cr[k]);
            end
            bck <= (c < (ratio ? 3 : 2)) == (fmt == 2'h2);
            c = (c + 1) % (ratio ? 6 : 4);
        end
    end
endmodule
`default_nettype wire

// [verif/tb_stereo_dac_clock_and_serial_front.sv]
// Self-checking bench for the stereo DAC front end
`timescale 1ns/1ns
`default_nettype none
module tb_stereo_dac_clock_and_serial_front;
    localparam int CALW = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ratio = 1'b0;
    logic en = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic rd_d = 1'b0;
    logic [1:0] fmt = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0;
    logic [17:0] l_smp = 18'h0;
    logic [17:0] r_smp = 18'h0;
    logic bck, word_channel_clock, sdat, tick, fclk, cal, ml, mr;
    logic [15:0] rdata;
    logic [15:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    sdcsf_top #(.CAL_WORDS(CALW)) dut (
        .CLK(clk),
        .RSTN(rstn),
        .CLOCK_RATIO_SELECT(ratio),
        .FORMAT_SELECT_LO(fmt[0]),
        .FORMAT_SELECT_HI(fmt[1]),
        .SERIAL_BIT_CLOCK(bck),
        .WORD_CHANNEL_CLOCK(word_channel_clock),
        .SERIAL_SAMPLE_IN(sdat),
        .REG_ADDR(addr),
        .REG_WDATA(wdata),
        .REG_WR(wr),
        .REG_RD(rd),
        .REG_RDATA(rdata),
        .FILTER_CLOCK_OUT(fclk),
        .CALIBRATION_ACTIVE_OUT(cal),
        .MOD_OUT_LEFT(ml),
        .MOD_OUT_RIGHT(mr)
    );
    sdcsf_src src (.clk(clk), .en(en), .ratio(ratio), .fmt(fmt), .l_smp(l_smp),
        .r_smp(r_smp), .bck(bck), .word_channel_clock(word_channel_clock), .sdat(sdat), .tick(tick));
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A read notes its expected answer; the monitor below compares it
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    function automatic logic [15:0] st(input logic [2:0] s, input logic c);
        return {9'h0, s, fmt, ratio, c};
    endfunction
    task automatic run_case(input logic r, input logic [1:0] f);
        int n;
        int w;
        int ones;
        logic [17:0] v;
        w = r ? 384 : 256;
        @(posedge clk);
        en <= 1'b0;
        rstn <= 1'b0;
        ratio <= r;
        fmt <= f;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({14'h0, fclk, cal}, 16'h1);
        // Pins need two edges through the synchroniser before status shows them
        repeat (2) @(posedge clk);
        bus(1'b0, 4'h0, st(sdcsf_pkg::ST_KICK, 1'b1));
        bus(1'b1, 4'h3, 16'h1);
        bus(1'b1, 4'hc, 16'hffff);
        bus(1'b0, 4'h0, st(sdcsf_pkg::ST_KICK, 1'b1));
        bus(1'b0, 4'h9, 16'h0);
        @(posedge clk);
        en <= 1'b1;
        n = 0;
        ones = 0;
        while (cal !== 1'b0 && n < 8 * w) begin
            @(negedge clk);
            n++;
            ones += int'(ml) + int'(mr);
        end
        chk(16'(n >= CALW * w && n <= (CALW + 2) * w), 16'h1);
        // Zero input during calibration leaves both streams near half density
        chk(16'(ones >= n - 8 && ones <= n + 8), 16'h1);
        bus(1'b0, 4'h0, st(sdcsf_pkg::ST_RUN, 1'b0));
        for (int i = 0; i < 3; i++) begin
            v = 18'($urandom);
            l_smp <= (i == 0) ? 18'h20000 : v;
            r_smp <= (i == 0) ? 18'h1ffff : {~v[17:2], 2'h0};
            @(posedge clk);
            @(posedge tick);
            @(posedge tick);
            repeat (12) @(posedge clk);
            bus(1'b0, 4'h1, l_smp[17:2]);
            bus(1'b0, 4'h2, r_smp[17:2]);
        end
        // Restart from the control register while running
        bus(1'b1, 4'h3, 16'h1);
        bus(1'b0, 4'h0, st(sdcsf_pkg::ST_CAL, 1'b1));
        @(negedge clk);
        chk({15'h0, cal}, 16'h1);
        $display("case ratio %0d format %0d done", r, f);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(77814));
        for (int r = 0; r < 2; r++) begin
            for (int f = 0; f < 4; f++) begin
                run_case(r[0], f[1:0]);
            end
        end
        tally_and_finish();
    end
    // Run needs about 2.6 ms; three times that means a hang
    initial begin
        #8000000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
